/* File: logic/dlc_line_control.sv */
// Dialer line control: hook switch, hold and hands-free keys, APB registers.
// Operation
// - Mute pin open-drain, software controlled
// - Line-break pin set by software only
// - Line-make high means line made
// - Hook rising edge: on-hook, interrupt
// - Hook falling edge: off-hook, clear states, interrupt
// - Hold low pulse: clear hands-free, toggle hold
// - Hold pulses honoured only while line made
// - Hands-free high pulse: clear hold, toggle hands-free
// - Hold state forces line made
// - Hands-free state forces line made
// - Select bit zero holds line-make low
// - Line low when select bit zero, or on-hook with states clear
// - Pin levels readable, control bits writable
module dlc_line_control
    import dlc_pkg::*;
(
    // Clock and reset.
    input wire logic clock_in,
    input wire logic reset_n_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [DLC_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Dialer pins.
    input wire logic hook_switch_in,
    input wire logic hold_request_in,
    input wire logic handsfree_request_in,
    output logic line_make_out,
    output logic hold_line_out,
    output logic handsfree_out,
    output logic speech_mute_out,
    output logic speech_mute_oe_n_out,
    output logic line_break_out,
    output logic line_break_oe_n_out,
    // Interrupt.
    output logic irq_out
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [2:0] prev_q;
    logic hold_q;
    logic hf_q;
    logic line_sel_q;
    logic break_float_q;
    logic mute_float_q;
    logic [DLC_IRQ_W-1:0] irq_stat_q;
    logic [DLC_IRQ_W-1:0] irq_mask_q;
    logic [DLC_IRQ_W-1:0] irq_evt;
    logic [DLC_IRQ_W-1:0] irq_stat_d;
    logic [DLC_IRQ_W-1:0] irq_mask_d;
    logic hook_rise;
    logic hook_fall;
    logic hold_pulse;
    logic hf_pulse;
    logic line_made;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    // Index 0 hook switch, 1 hold request, 2 hands-free request.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= DLC_SYNC_RST;
            sync_q <= DLC_SYNC_RST;
            prev_q <= DLC_SYNC_RST;
        end else begin
            meta_q <= {handsfree_request_in, hold_request_in,
                       hook_switch_in};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Synchroniser flops reset to each pin's idle level, so that reset
    // itself never looks like a key press or a hook edge.
    assign hook_rise = sync_q[0] & ~prev_q[0];
    assign hook_fall = ~sync_q[0] & prev_q[0];
    // A hold pulse is acted on at its trailing (rising) edge.
    assign hold_pulse = sync_q[1] & ~prev_q[1] & line_made;
    // A hands-free pulse is acted on at its trailing (falling) edge.
    assign hf_pulse = ~sync_q[2] & prev_q[2];

    // Line is made while the select bit is set, unless on-hook with both states clear.
    assign line_made = line_sel_q &
        (~sync_q[0] | hold_q | hf_q);

    // A hook fall takes priority over key pulses in the same cycle.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hold_q <= 1'b0;
            hf_q <= 1'b0;
        end else if (hook_fall) begin
            hold_q <= 1'b0;
            hf_q <= 1'b0;
        end else if (hold_pulse) begin
            hf_q <= 1'b0;
            hold_q <= ~hold_q;
        end else if (hf_pulse) begin
            hold_q <= 1'b0;
            hf_q <= ~hf_q;
        end
    end

    assign hold_line_out = hold_q;
    assign handsfree_out = hf_q;

    // Output flop keeps the line-make pin glitch free.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            line_make_out <= 1'b0;
        end else begin
            line_make_out <= line_made;
        end
    end

    // Open-drain pins pull low whenever their float bit is clear.
    assign speech_mute_out = 1'b0;
    assign speech_mute_oe_n_out = mute_float_q;
    assign line_break_out = 1'b0;
    assign line_break_oe_n_out = break_float_q;

    // APB slave, zero wait states.
    assign pready_out = 1'b1;
    assign addr_ok = (paddr_in == DLC_DIALERIO_ADDR) ||
        (paddr_in == DLC_IRQ_STAT_ADDR) || (paddr_in == DLC_IRQ_MASK_ADDR) ||
        (paddr_in == DLC_VECTOR_ADDR);
    assign pslverr_out = psel_in & penable_in & ~addr_ok;
    assign wr_en = psel_in & penable_in & pwrite_in & pstrb_in[0];
    assign rd_en = psel_in & ~penable_in & ~pwrite_in;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            line_sel_q <= DLC_CTRL_RST;
            break_float_q <= DLC_CTRL_RST;
            mute_float_q <= DLC_CTRL_RST;
            irq_mask_q <= DLC_IRQ_MASK_RST;
        end else if (wr_en) begin
            if (paddr_in == DLC_DIALERIO_ADDR) begin
                line_sel_q <= pwdata_in[DLC_BIT_LINE_SEL];
                break_float_q <= pwdata_in[DLC_BIT_BREAK_FLOAT];
                mute_float_q <= pwdata_in[DLC_BIT_MUTE_FLOAT];
            end
            if (paddr_in == DLC_IRQ_MASK_ADDR) begin
                irq_mask_q <= pwdata_in[DLC_IRQ_W-1:0];
            end
        end
    end

    // New events win over a write-one clear in the same cycle.
    assign irq_evt = {hf_pulse & ~hook_fall, hold_pulse & ~hook_fall,
                      hook_fall, hook_rise};
    // Next values let the pin follow status and mask with no extra lag.
    always_comb begin
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q | irq_evt;
        if (wr_en && paddr_in == DLC_IRQ_MASK_ADDR) begin
            irq_mask_d = pwdata_in[DLC_IRQ_W-1:0];
        end
        if (wr_en && paddr_in == DLC_IRQ_STAT_ADDR) begin
            irq_stat_d = (irq_stat_q & ~pwdata_in[DLC_IRQ_W-1:0]) | irq_evt;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // A set mask bit hides its event from the pin, not from the status.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_d & ~irq_mask_d);
        end
    end

    // Read data is latched in the setup cycle and valid in the access phase.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr_in)
                DLC_DIALERIO_ADDR: prdata_out <= {24'h00_0000, mute_float_q,
                    break_float_q, line_sel_q, sync_q[0], hold_q, sync_q[1],
                    hf_q, sync_q[2]};
                DLC_IRQ_STAT_ADDR: prdata_out <= {28'h000_0000, irq_stat_q};
                DLC_IRQ_MASK_ADDR: prdata_out <= {28'h000_0000, irq_mask_q};
                DLC_VECTOR_ADDR: prdata_out <= {24'h00_0000, DLC_VECTOR};
                default: prdata_out <= 32'h0000_0000;
            endcase
        end
    end

    property p_fall_clears;
        @(posedge clock_in) disable iff (!reset_n_in)
        hook_fall |=> (!hold_q && !hf_q);
    endproperty
    a_fall_clears: assert property (p_fall_clears)
        else $error("Hook fall did not clear states");

    property p_hold_toggle;
        @(posedge clock_in) disable iff (!reset_n_in)
        (hold_pulse && !hook_fall) |=> (hold_q != $past(hold_q)) && !hf_q;
    endproperty
    a_hold_toggle: assert property (p_hold_toggle)
        else $error("Hold pulse did not toggle hold state");

    property p_hf_toggle;
        @(posedge clock_in) disable iff (!reset_n_in)
        (hf_pulse && !hold_pulse && !hook_fall) |=>
            (hf_q != $past(hf_q)) && !hold_q;
    endproperty
    a_hf_toggle: assert property (p_hf_toggle)
        else $error("Hands-free pulse did not toggle state");

    property p_hold_ignored;
        @(posedge clock_in) disable iff (!reset_n_in)
        (!line_made && !hook_fall && !hf_pulse) |=> $stable(hold_q);
    endproperty
    a_hold_ignored: assert property (p_hold_ignored)
        else $error("Hold state changed while line broken");

    property p_make_states;
        @(posedge clock_in) disable iff (!reset_n_in)
        (line_sel_q && (hold_q || hf_q)) |=> line_make_out;
    endproperty
    a_make_states: assert property (p_make_states)
        else $error("Line not made with hold or hands-free");

    property p_sel_low;
        @(posedge clock_in) disable iff (!reset_n_in)
        !line_sel_q |=> !line_make_out;
    endproperty
    a_sel_low: assert property (p_sel_low)
        else $error("Line made with select bit clear");

    property p_onhook_break;
        @(posedge clock_in) disable iff (!reset_n_in)
        (sync_q[0] && !hold_q && !hf_q) |=> !line_make_out;
    endproperty
    a_onhook_break: assert property (p_onhook_break)
        else $error("Line made while idle on-hook");

    property p_edge_irq;
        @(posedge clock_in) disable iff (!reset_n_in)
        (hook_rise && !irq_mask_d[DLC_IRQ_ON_HOOK]) |=> irq_out;
    endproperty
    a_edge_irq: assert property (p_edge_irq)
        else $error("Hook rise did not raise interrupt");

    property p_break_sw;
        @(posedge clock_in) disable iff (!reset_n_in)
        !(wr_en && paddr_in == DLC_DIALERIO_ADDR) |=>
            $stable(line_break_oe_n_out);
    endproperty
    a_break_sw: assert property (p_break_sw)
        else $error("Line-break pin changed without a write");

    property p_mute_sw;
        @(posedge clock_in) disable iff (!reset_n_in)
        !(wr_en && paddr_in == DLC_DIALERIO_ADDR) |=>
            $stable(speech_mute_oe_n_out);
    endproperty
    a_mute_sw: assert property (p_mute_sw)
        else $error("Mute pin changed without a write");

    property p_fall_irq;
        @(posedge clock_in) disable iff (!reset_n_in)
        hook_fall |=> irq_stat_q[DLC_IRQ_OFF_HOOK];
    endproperty
    a_fall_irq: assert property (p_fall_irq)
        else $error("Hook fall did not set its status bit");

    property p_hold_irq;
        @(posedge clock_in) disable iff (!reset_n_in)
        (hold_pulse && !hook_fall) |=> irq_stat_q[DLC_IRQ_HOLD];
    endproperty
    a_hold_irq: assert property (p_hold_irq)
        else $error("Hold pulse did not set its status bit");

    property p_hf_irq;
        @(posedge clock_in) disable iff (!reset_n_in)
        (hf_pulse && !hook_fall) |=> irq_stat_q[DLC_IRQ_HF];
    endproperty
    a_hf_irq: assert property (p_hf_irq)
        else $error("Hands-free pulse did not set its status bit");

    property p_stat_sticky;
        @(posedge clock_in) disable iff (!reset_n_in)
        !(wr_en && paddr_in == DLC_IRQ_STAT_ADDR) |=>
            ((irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q));
    endproperty
    a_stat_sticky: assert property (p_stat_sticky)
        else $error("Status bit dropped without a clear write");

    property p_sync_stage;
        @(posedge clock_in) disable iff (!reset_n_in)
        1'b1 |=> (sync_q == $past(meta_q));
    endproperty
    a_sync_stage: assert property (p_sync_stage)
        else $error("Second synchroniser stage skipped");

    property p_offhook_make;
        @(posedge clock_in) disable iff (!reset_n_in)
        (line_sel_q && !sync_q[0]) |=> line_make_out;
    endproperty
    a_offhook_make: assert property (p_offhook_make)
        else $error("Line not made while off-hook");
endmodule : dlc_line_control

/* File: logic/dlc_pkg.sv */
// Register map, field positions and reset values for dialer control.
package dlc_pkg;
    localparam int DLC_ADDR_W = 8;
    localparam logic [7:0] DLC_DIALERIO_ADDR = 8'h00;
    localparam logic [7:0] DLC_IRQ_STAT_ADDR = 8'h04;
    localparam logic [7:0] DLC_IRQ_MASK_ADDR = 8'h08;
    localparam logic [7:0] DLC_VECTOR_ADDR = 8'h0C;
    // Dialer status/control register fields.
    localparam int DLC_BIT_HF_REQ = 0;
    localparam int DLC_BIT_HF_OUT = 1;
    localparam int DLC_BIT_HOLD_REQ = 2;
    localparam int DLC_BIT_HOLD_OUT = 3;
    localparam int DLC_BIT_HOOK = 4;
    localparam int DLC_BIT_LINE_SEL = 5;
    localparam int DLC_BIT_BREAK_FLOAT = 6;
    localparam int DLC_BIT_MUTE_FLOAT = 7;
    // Interrupt status fields.
    localparam int DLC_IRQ_ON_HOOK = 0;
    localparam int DLC_IRQ_OFF_HOOK = 1;
    localparam int DLC_IRQ_HOLD = 2;
    localparam int DLC_IRQ_HF = 3;
    localparam int DLC_IRQ_W = 4;
    localparam logic [7:0] DLC_VECTOR = 8'h18;
    localparam logic [DLC_IRQ_W-1:0] DLC_IRQ_MASK_RST = 4'h0;
    localparam logic DLC_CTRL_RST = 1'b0;
    // Synchroniser reset follows the idle pins: hands-free low, others high.
    localparam logic [2:0] DLC_SYNC_RST = 3'h3;
endpackage : dlc_pkg

/* File: dv/dlc_line_partner.sv */
// Hook switch, hold and hands-free keys, and line interface pull-ups.
module dlc_line_partner (
    // Clock.
    input wire logic clock_in,
    // Key and switch drive.
    output logic hook_switch_out,
    output logic hold_request_out,
    output logic handsfree_request_out,
    // Open-drain pins from the block.
    input wire logic speech_mute_in,
    input wire logic speech_mute_oe_n_in,
    input wire logic line_break_in,
    input wire logic line_break_oe_n_in,
    output logic mute_level_out,
    output logic break_level_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Both pins see an external pull-up, so a released pin reads high.
    assign mute_level_out = speech_mute_oe_n_in ? 1'h1 :
        speech_mute_in;
    assign break_level_out = line_break_oe_n_in ? 1'h1 :
        line_break_in;

    initial begin
        hook_switch_out = 1'h1;
        hold_request_out = 1'h1;
        handsfree_request_out = 1'h0;
    end

    // Pulses last four edges so the synchroniser sees each one whole.
    task automatic key(input logic hold);
        if (hold) begin
            hold_request_out <= 1'h0;
        end else begin
            handsfree_request_out <= 1'h1;
        end
        repeat (4) @(posedge clock_in);
        hold_request_out <= 1'h1;
        handsfree_request_out <= 1'h0;
        repeat (8) @(posedge clock_in);
    endtask : key

    task automatic hook(input logic level);
        hook_switch_out <= level;
        repeat (8) @(posedge clock_in);
    endtask : hook
endmodule : dlc_line_partner

/* File: dv/dlc_line_control_tb.sv */
// Self-checking bench for the dialer line control block.
module dlc_line_control_tb import dlc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in, reset_n_in, psel, penable, pwrite, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, hook, hold, hf, line, hold_q, hf_q, irq;
    logic mute, mute_oe_n, brk, brk_oe_n, mute_lvl, brk_lvl;
    int fails = 0, tests_run = 0, cycles = 0;

    dlc_line_control u_dlc_line_control (.clock_in(clock_in),
        .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .hook_switch_in(hook),
        .hold_request_in(hold), .handsfree_request_in(hf),
        .line_make_out(line), .hold_line_out(hold_q),
        .handsfree_out(hf_q), .speech_mute_out(mute),
        .speech_mute_oe_n_out(mute_oe_n), .line_break_out(brk),
        .line_break_oe_n_out(brk_oe_n), .irq_out(irq));
    dlc_line_partner u_dlc_line_partner (.clock_in(clock_in),
        .hook_switch_out(hook), .hold_request_out(hold),
        .handsfree_request_out(hf), .speech_mute_in(mute),
        .speech_mute_oe_n_in(mute_oe_n), .line_break_in(brk),
        .line_break_oe_n_in(brk_oe_n), .mute_level_out(mute_lvl),
        .break_level_out(brk_lvl));

    initial begin
        clock_in = 1'h0;
        forever #50 clock_in = ~clock_in;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // A hung bus ends the run here as a mismatch.
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Entered just after a rising edge; waits for pready at an edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'h1;
        do @(posedge clock_in); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // One idle edge, so a following call never drives psel twice at once.
        @(posedge clock_in);
    endtask : apb

    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(n, e, rd);
    endtask : rchk

    task automatic pins(input string n, input logic [3:0] e);
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        chk(n, {28'h0, e}, {28'h0, line, hold_q, hf_q, irq});
        @(posedge clock_in);
    endtask : pins

    initial begin
        reset_n_in = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (6) @(posedge clock_in);
        reset_n_in <= 1'h1;
        @(negedge clock_in);
        chk("reset pins", 32'h0, {26'h0, line, hold_q, hf_q, irq,
            mute_lvl, brk_lvl});
        @(posedge clock_in);
        rchk("dialer", DLC_DIALERIO_ADDR, 32'h14);
        rchk("mask", DLC_IRQ_MASK_ADDR, 32'h0);
        apb(1'h1, DLC_DIALERIO_ADDR, 32'hE0);
        pins("on-hook idle", 4'h0);
        chk("open drain", 32'h3, {30'h0, mute_lvl, brk_lvl});
        u_dlc_line_partner.key(1'h1);
        pins("hold ignored", 4'h0);
        u_dlc_line_partner.key(1'h0);
        pins("hands-free", 4'hB);
        rchk("status hf", DLC_IRQ_STAT_ADDR, 32'h8);
        apb(1'h1, DLC_IRQ_MASK_ADDR, 32'hF);
        pins("masked", 4'hA);
        apb(1'h1, DLC_IRQ_STAT_ADDR, 32'hF);
        apb(1'h1, DLC_IRQ_MASK_ADDR, 32'h0);
        rchk("status clr", DLC_IRQ_STAT_ADDR, 32'h0);
        u_dlc_line_partner.key(1'h1);
        pins("hold", 4'hD);
        rchk("dialer hold", DLC_DIALERIO_ADDR, 32'hFC);
        u_dlc_line_partner.hook(1'h0);
        pins("off-hook", 4'h9);
        rchk("dialer off", DLC_DIALERIO_ADDR, 32'hE4);
        u_dlc_line_partner.key(1'h1);
        u_dlc_line_partner.hook(1'h1);
        pins("on-hook hold", 4'hD);
        rchk("status all", DLC_IRQ_STAT_ADDR, 32'h7);
        rchk("vector", DLC_VECTOR_ADDR, DLC_VECTOR);
        pstrb <= 4'h0;
        apb(1'h1, DLC_DIALERIO_ADDR, 32'h0);
        pstrb <= 4'hF;
        rchk("strobe off", DLC_DIALERIO_ADDR, 32'hFC);
        apb(1'h0, 8'h10, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'h1, DLC_DIALERIO_ADDR, 32'h0);
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        chk("select off", 32'h0,
            {29'h0, line, mute_lvl, brk_lvl});
        report_and_stop();
    end
endmodule : dlc_line_control_tb
